// ===== src/dbs_pkg.sv
// Overview of operation
// - One column strobe per bank, addressed bank only
// - All column strobes released at cycle end
// - Static-column parts run page-mode strobes
// - Four write strobes, one per byte lane
// - Parity latch clock pulses on reads
// - Address bits 18 and 19 driven separately
// - Refresh runs a row-strobe-only cycle
// - Refresh also starts channel memory read
// - Ready after refresh and channel read done
// - Direction low reads, high writes
// - Lane enables follow active byte enables
// - Address latch strobe captures cycle address
// - Page mode keeps row strobe within row
// - Normal mode precharges row strobe every access
// - Select low row, high column
package dbs_pkg;
   localparam int NUM_BANKS = 4;
   localparam int NUM_LANES = 4;
   localparam int ROW_BITS = 10;
   localparam int CLOCK_NS = 100;
   // Row strobe precharge time and derived cycles, rounded up
   localparam int PRECHARGE_NS = 200;
   localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLOCK_NS - 1) / CLOCK_NS;
   // Row-to-column address hold, rounded up
   localparam int ROW_HOLD_NS = 100;
   localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
   // Column strobe active width, rounded up
   localparam int CAS_WIDTH_NS = 200;
   localparam int CAS_WIDTH_CYC = (CAS_WIDTH_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [NUM_BANKS-1:0] STROBES_IDLE = 4'h0;
   localparam logic [ROW_BITS-1:0] ROW_RESET = 10'h000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PRECHARGE, ST_ROW, ST_COLUMN, ST_DONE, ST_REFRESH
   } dbs_state_e;
endpackage

// ===== src/dbs_bank_decode.sv
`timescale 1ns/100ps
// One-hot bank strobe from the bank number
module dbs_bank_decode #(
   parameter int BANKS = dbs_pkg::NUM_BANKS
) (
   input wire logic [1:0] i_bank,
   input wire logic i_enable,
   output logic [BANKS-1:0] o_onehot
);
   // Only the addressed bank gets a strobe
   always_comb begin
      o_onehot = '0;
      if (i_enable) begin
         o_onehot[i_bank] = 1'b1;
      end
   end
endmodule // dbs_bank_decode

// ===== src/dbs_delay_count.sv
`timescale 1ns/100ps
// Loadable down counter for the strobe timing phases
module dbs_delay_count #(
   parameter int W = dbs_pkg::CNT_W
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   output logic o_zero
);
   logic [W-1:0] count_reg;
   // Load wins over counting so a new phase always starts cleanly
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         count_reg <= '0;
      end else if (i_load) begin
         count_reg <= i_value;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end
   // Plain compare: the load is decoded from this flag, so it must not look back at the load
   assign o_zero = (count_reg == '0);
endmodule // dbs_delay_count

// ===== src/dbs_strobe_control.sv
`timescale 1ns/100ps
// DRAM-side strobes, buffer controls and refresh sequencing
module dbs_strobe_control (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cycle_start,
   input wire logic i_write,
   input wire logic [3:0] i_byte_enable,
   input wire logic [1:0] i_bank,
   input wire logic [9:0] i_row,
   input wire logic i_addr_18,
   input wire logic i_addr_19,
   input wire logic i_page_mode,
   input wire logic i_refresh,
   input wire logic i_channel_done,
   output logic o_ras,
   output logic [3:0] o_cas,
   output logic [3:0] o_dram_byte_write,
   output logic o_parity_latch_clock,
   output logic o_split_addr_bit_lo,
   output logic o_split_addr_bit_hi,
   output logic o_row_col_select,
   output logic o_dram_buffer_direction,
   output logic [3:0] o_dram_lane_enable,
   output logic o_memory_address_latch_strobe,
   output logic o_channel_read_start,
   output logic o_ready
);
   dbs_pkg::dbs_state_e state_reg;
   logic refresh_s1_reg;
   logic refresh_s2_reg;
   logic refresh_prev_reg;
   logic chan_s1_reg;
   logic chan_s2_reg;
   logic write_reg;
   logic [3:0] be_reg;
   logic [1:0] bank_reg;
   logic [9:0] open_row_reg;
   logic row_open_reg;
   logic refresh_dram_done_reg;
   logic chan_done_reg;
   logic timer_load;
   logic [dbs_pkg::CNT_W-1:0] timer_value;
   logic timer_zero;
   logic cas_enable;
   logic [3:0] cas_onehot;
   logic refresh_rise;
   logic page_hit;

   // Refresh and channel completion come from other chips: two flops each
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         refresh_s1_reg <= 1'b0;
         refresh_s2_reg <= 1'b0;
         refresh_prev_reg <= 1'b0;
         chan_s1_reg <= 1'b0;
         chan_s2_reg <= 1'b0;
      end else begin
         refresh_s1_reg <= i_refresh;
         refresh_s2_reg <= refresh_s1_reg;
         if (state_reg == dbs_pkg::ST_IDLE || !refresh_s2_reg) begin // Pending until idle
            refresh_prev_reg <= refresh_s2_reg;
         end
         chan_s1_reg <= i_channel_done;
         chan_s2_reg <= chan_s1_reg;
      end
   end
   assign refresh_rise = refresh_s2_reg && !refresh_prev_reg;
   assign page_hit = i_page_mode && row_open_reg && (open_row_reg == i_row);

   dbs_delay_count #(.W(dbs_pkg::CNT_W)) u_timer (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_load(timer_load),
      .i_value(timer_value),
      .o_zero(timer_zero)
   );

   // Phase timer reloads on entry to each timed state; column and done load nothing
   always_comb begin
      timer_load = 1'b0;
      timer_value = dbs_pkg::CNT_ZERO;
      unique case (state_reg)
         dbs_pkg::ST_IDLE: begin
            if (refresh_rise || (i_cycle_start && !page_hit)) begin
               timer_load = 1'b1;
               timer_value = dbs_pkg::CNT_W'(dbs_pkg::PRECHARGE_CYC);
            end else if (i_cycle_start) begin
               timer_load = 1'b1;
               timer_value = dbs_pkg::CNT_W'(dbs_pkg::CAS_WIDTH_CYC);
            end
         end
         dbs_pkg::ST_PRECHARGE: begin
            if (timer_zero) begin
               timer_load = 1'b1;
               timer_value = dbs_pkg::CNT_W'(dbs_pkg::ROW_HOLD_CYC);
            end
         end
         dbs_pkg::ST_ROW: begin
            if (timer_zero) begin
               timer_load = 1'b1;
               timer_value = dbs_pkg::CNT_W'(dbs_pkg::CAS_WIDTH_CYC);
            end
         end
         dbs_pkg::ST_REFRESH: begin
            if (!refresh_dram_done_reg) begin
               timer_load = (state_reg == dbs_pkg::ST_REFRESH) && timer_zero && !o_ras;
               timer_value = dbs_pkg::CNT_W'(dbs_pkg::CAS_WIDTH_CYC);
            end
         end
         dbs_pkg::ST_COLUMN, dbs_pkg::ST_DONE: begin
         end
      endcase
   end

   // Cycle sequencer; refresh takes priority over a processor cycle
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= dbs_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            dbs_pkg::ST_IDLE: begin
               if (refresh_rise) begin
                  state_reg <= dbs_pkg::ST_REFRESH;
               end else if (i_cycle_start && page_hit) begin
                  state_reg <= dbs_pkg::ST_COLUMN;
               end else if (i_cycle_start) begin
                  state_reg <= dbs_pkg::ST_PRECHARGE;
               end
            end
            dbs_pkg::ST_PRECHARGE: if (timer_zero) state_reg <= dbs_pkg::ST_ROW;
            dbs_pkg::ST_ROW: if (timer_zero) state_reg <= dbs_pkg::ST_COLUMN;
            dbs_pkg::ST_COLUMN: if (timer_zero) state_reg <= dbs_pkg::ST_DONE;
            dbs_pkg::ST_DONE: state_reg <= dbs_pkg::ST_IDLE;
            dbs_pkg::ST_REFRESH: begin
               if (refresh_dram_done_reg && chan_done_reg) begin
                  state_reg <= dbs_pkg::ST_DONE;
               end
            end
         endcase
      end
   end

   // Captured cycle attributes stand for the whole access
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         write_reg <= 1'b0;
         be_reg <= 4'h0;
         bank_reg <= 2'h0;
      end else if (state_reg == dbs_pkg::ST_IDLE && i_cycle_start && !refresh_rise) begin
         write_reg <= i_write;
         be_reg <= i_byte_enable;
         bank_reg <= i_bank;
      end
   end

   // Open row tracking; refresh and normal mode both close the page
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         open_row_reg <= dbs_pkg::ROW_RESET;
         row_open_reg <= 1'b0;
      end else if (state_reg == dbs_pkg::ST_REFRESH) begin
         row_open_reg <= 1'b0;
      end else if (state_reg == dbs_pkg::ST_ROW && timer_zero) begin
         open_row_reg <= i_row;
         row_open_reg <= i_page_mode;
      end else if (state_reg == dbs_pkg::ST_DONE && !i_page_mode) begin
         row_open_reg <= 1'b0;
      end
   end

   // Row strobe: dropped for precharge, else held while a page stays open
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_ras <= 1'b0;
      end else if (state_reg == dbs_pkg::ST_IDLE && (refresh_rise || (i_cycle_start && !page_hit))) begin
         o_ras <= 1'b0;
      end else if (state_reg == dbs_pkg::ST_PRECHARGE && timer_zero) begin
         o_ras <= 1'b1;
      end else if (state_reg == dbs_pkg::ST_REFRESH && timer_zero && !refresh_dram_done_reg) begin
         o_ras <= !o_ras;
      end else if (state_reg == dbs_pkg::ST_DONE) begin
         o_ras <= row_open_reg && i_page_mode;
      end
   end

   // Refresh completion flags; the channel done event is held once seen
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         refresh_dram_done_reg <= 1'b0;
         chan_done_reg <= 1'b0;
      end else if (state_reg != dbs_pkg::ST_REFRESH) begin
         refresh_dram_done_reg <= 1'b0;
         chan_done_reg <= 1'b0;
      end else begin
         if (o_ras && timer_zero) begin
            refresh_dram_done_reg <= 1'b1;
         end
         if (chan_s2_reg) begin
            chan_done_reg <= 1'b1;
         end
      end
   end

   // Column strobes exist only in the column phase; static-column parts see the same
   assign cas_enable = (state_reg == dbs_pkg::ST_COLUMN);
   dbs_bank_decode #(.BANKS(dbs_pkg::NUM_BANKS)) u_decode (
      .i_bank(bank_reg),
      .i_enable(cas_enable),
      .o_onehot(cas_onehot)
   );

   // Registered DRAM strobes, all released when the cycle ends
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cas <= dbs_pkg::STROBES_IDLE;
         o_dram_byte_write <= 4'h0;
      end else begin
         o_cas <= cas_onehot;
         o_dram_byte_write <= (cas_enable && write_reg) ? be_reg : 4'h0;
      end
   end

   // Parity latch clock rises at the end of the read column phase
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_parity_latch_clock <= 1'b0;
      end else begin
         o_parity_latch_clock <= cas_enable && !write_reg && timer_zero;
      end
   end

   // Split address bits and row/column select
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_split_addr_bit_lo <= 1'b0;
         o_split_addr_bit_hi <= 1'b0;
         o_row_col_select <= 1'b0;
      end else begin
         o_split_addr_bit_lo <= i_addr_18;
         o_split_addr_bit_hi <= i_addr_19;
         o_row_col_select <= (state_reg == dbs_pkg::ST_ROW && timer_zero) ||
            (state_reg == dbs_pkg::ST_COLUMN) ||
            (state_reg == dbs_pkg::ST_IDLE && i_cycle_start && page_hit);
      end
   end

   // Direction is set at cycle capture, lanes open one cycle into the column phase
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_dram_buffer_direction <= 1'b0;
         o_dram_lane_enable <= 4'h0;
      end else begin
         if (state_reg == dbs_pkg::ST_IDLE && i_cycle_start && !refresh_rise) begin
            o_dram_buffer_direction <= i_write;
         end
         o_dram_lane_enable <= (state_reg == dbs_pkg::ST_COLUMN) ? be_reg : 4'h0;
      end
   end

   // Latch strobe, channel read kick and ready pulses
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_memory_address_latch_strobe <= 1'b0;
         o_channel_read_start <= 1'b0;
         o_ready <= 1'b0;
      end else begin
         o_memory_address_latch_strobe <= state_reg == dbs_pkg::ST_IDLE && i_cycle_start;
         o_channel_read_start <= state_reg == dbs_pkg::ST_IDLE && refresh_rise;
         o_ready <= state_reg == dbs_pkg::ST_DONE;
      end
   end

   AST_CAS_ONEHOT: assert property (@(posedge i_clock) disable iff (i_rst)
      $countones(o_cas) <= 1) else $error("More than one column strobe");
   AST_CAS_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
      state_reg == dbs_pkg::ST_DONE |=> o_cas == 4'h0) else $error("Strobe held after cycle");
   AST_WR_LANES: assert property (@(posedge i_clock) disable iff (i_rst)
      o_dram_byte_write != 4'h0 |-> o_dram_buffer_direction) else $error("Write on read");
   AST_PAR_READ: assert property (@(posedge i_clock) disable iff (i_rst)
      o_parity_latch_clock |-> !write_reg) else $error("Parity clock on write");
   AST_SPLIT: assert property (@(posedge i_clock) disable iff (i_rst)
      ##1 o_split_addr_bit_hi == $past(i_addr_19)) else $error("Split bit wrong");
   AST_REF_NOCAS: assert property (@(posedge i_clock) disable iff (i_rst)
      state_reg == dbs_pkg::ST_REFRESH |=> o_cas == 4'h0) else $error("Column strobe in refresh");
   AST_REF_CHAN: assert property (@(posedge i_clock) disable iff (i_rst)
      state_reg == dbs_pkg::ST_IDLE && refresh_rise |=> o_channel_read_start)
      else $error("No channel read");
   AST_REF_READY: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_ready) && $past(state_reg, 2) == dbs_pkg::ST_REFRESH |-> $past(chan_done_reg, 2))
      else $error("Ready before channel done");
   AST_LANE_DIR: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_dram_lane_enable != 4'h0) |-> $stable(o_dram_buffer_direction))
      else $error("Direction moved with lanes");

   // Lane, precharge, row strobe and address select guards
   AST_LANE_BE: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_dram_lane_enable & ~be_reg) == 4'h0) else $error("Lane without byte enable");
   AST_PRECHARGE_LOW: assert property (@(posedge i_clock) disable iff (i_rst)
      state_reg == dbs_pkg::ST_PRECHARGE |-> !o_ras) else $error("No precharge");
   AST_ROW_SELECT: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_ras) |-> !o_row_col_select) else $error("Select high at row strobe");
   AST_CAS_SELECT: assert property (@(posedge i_clock) disable iff (i_rst)
      o_cas != 4'h0 |-> o_row_col_select) else $error("Strobe without column");
endmodule // dbs_strobe_control

// ===== tb/dbs_far_side_model.sv
`timescale 1ns/100ps
// Far side: channel slave that answers a read start, and a watcher on the bank strobes
module dbs_far_side_model (
   input wire logic i_clock,
   input wire logic [3:0] i_delay,
   input wire logic i_ras,
   input wire logic [3:0] i_cas,
   input wire logic i_channel_read_start,
   output logic o_channel_done,
   output int o_bad_cas
);
   int wait_cnt = 0;
   // Done held 3 cycles so the two-flop synchroniser cannot miss it
   initial o_channel_done = 1'b0;
   always @(posedge i_clock) begin
      if (i_channel_read_start === 1'b1) wait_cnt <= i_delay + 3;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      o_channel_done <= (wait_cnt > 0 && wait_cnt <= 3);
   end
   // A column strobe with no row strobe would corrupt the banks
   initial o_bad_cas = 0;
   always @(posedge i_clock) begin
      if (|i_cas && i_ras !== 1'b1) o_bad_cas <= o_bad_cas + 1;
   end
endmodule // dbs_far_side_model

// ===== tb/test_dbs_strobe_control.sv
`timescale 1ns/100ps
module test_dbs_strobe_control;
   logic i_clock, i_rst, i_cycle_start, i_write, i_page_mode, i_refresh, i_addr_18, i_addr_19;
   logic [3:0] i_byte_enable, dly, o_cas, o_dram_byte_write, o_dram_lane_enable;
   logic [1:0] i_bank;
   logic [9:0] i_row;
   logic i_channel_done, o_ras, o_parity_latch_clock, o_split_addr_bit_lo, o_split_addr_bit_hi;
   logic o_row_col_select, o_dram_buffer_direction, o_memory_address_latch_strobe;
   logic o_channel_read_start, o_ready, ras_q, w_exp;
   logic [3:0] cas_acc, lane_acc, bw_acc;
   int n_mismatch = 0, n_tests = 0, cyc = 0, bad_cas;
   int par_n, memory_address_latch_strobe_n, dir_bad, mux_bad, hot_bad, ras_fall, start_n, done_at, ready_at;

   dbs_strobe_control dut_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_cycle_start(i_cycle_start), .i_write(i_write),
      .i_byte_enable(i_byte_enable), .i_bank(i_bank), .i_row(i_row), .i_addr_18(i_addr_18),
      .i_addr_19(i_addr_19), .i_page_mode(i_page_mode), .i_refresh(i_refresh),
      .i_channel_done(i_channel_done), .o_ras(o_ras), .o_cas(o_cas),
      .o_dram_byte_write(o_dram_byte_write), .o_parity_latch_clock(o_parity_latch_clock),
      .o_split_addr_bit_lo(o_split_addr_bit_lo), .o_split_addr_bit_hi(o_split_addr_bit_hi),
      .o_row_col_select(o_row_col_select), .o_dram_buffer_direction(o_dram_buffer_direction),
      .o_dram_lane_enable(o_dram_lane_enable),
      .o_memory_address_latch_strobe(o_memory_address_latch_strobe),
      .o_channel_read_start(o_channel_read_start), .o_ready(o_ready));
   dbs_far_side_model far_u (.i_clock(i_clock), .i_delay(dly), .i_ras(o_ras), .i_cas(o_cas),
      .i_channel_read_start(o_channel_read_start), .o_channel_done(i_channel_done),
      .o_bad_cas(bad_cas));

   // Clock at 10 MHz
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end

   // Observe on the falling edge, where registered outputs have settled
   always @(negedge i_clock) begin
      cas_acc = cas_acc | o_cas;
      lane_acc = lane_acc | o_dram_lane_enable;
      bw_acc = bw_acc | o_dram_byte_write;
      par_n += o_parity_latch_clock;
      memory_address_latch_strobe_n += o_memory_address_latch_strobe;
      start_n += o_channel_read_start;
      if (|o_dram_lane_enable && o_dram_buffer_direction !== w_exp) dir_bad++;
      if (|o_cas && o_row_col_select !== 1'b1) mux_bad++;
      if ($countones(o_cas) > 1) hot_bad++;
      if (ras_q === 1'b1 && o_ras === 1'b0) ras_fall++;
      ras_q = o_ras;
      if (o_ready === 1'b1) ready_at = cyc;
      if (i_channel_done === 1'b1 && done_at == 0) done_at = cyc;
   end

   // Hang guard: the whole run needs well under 2000 cycles
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 4000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic clr();
      cas_acc = 0; lane_acc = 0; bw_acc = 0; par_n = 0; memory_address_latch_strobe_n = 0; dir_bad = 0;
      mux_bad = 0; hot_bad = 0; ras_fall = 0; start_n = 0; done_at = 0; ready_at = 0;
   endtask

   // Wait for the ready pulse under a bound
   task automatic wait_ready(input int lim);
      int k;
      k = 0;
      while (o_ready !== 1'b1 && k < lim) begin
         @(negedge i_clock);
         #1; // Let the falling-edge observer finish first
         k++;
      end
      chk("ready", {7'h00, o_ready}, 8'h01);
   endtask

   // One processor cycle; request is a single-cycle pulse taken in idle
   task automatic op(input logic w, input logic [3:0] be, input logic [1:0] b,
                     input logic [9:0] r);
      @(posedge i_clock);
      clr();
      w_exp = w;
      i_cycle_start <= 1'b1;
      i_write <= w;
      i_byte_enable <= be;
      i_bank <= b;
      i_row <= r;
      @(posedge i_clock);
      i_cycle_start <= 1'b0;
      wait_ready(60);
      chk("cas_at_end", {4'h0, o_cas}, 8'h00);
      chk("dir_bad", dir_bad[7:0], 8'h00);
      chk("mux_bad", mux_bad[7:0], 8'h00);
      chk("hot_bad", hot_bad[7:0], 8'h00);
      chk("latch", memory_address_latch_strobe_n[7:0], 8'h01);
      chk("lanes", {4'h0, lane_acc}, {4'h0, be});
   endtask

   // Reads to each bank in row/column mode
   task automatic t_read_banks();
      for (int b = 0; b < 4; b++) begin
         op(1'b0, 4'h1 << b, b[1:0], 10'h155);
         chk("cas_bank", {4'h0, cas_acc}, {4'h0, 4'h1 << b});
         chk("bw_read", {4'h0, bw_acc}, 8'h00);
         chk("parity", par_n[7:0], 8'h01);
         chk("precharge", {7'h00, ras_fall > 0}, 8'h01);
      end
   endtask

   // Writes with assorted byte lanes
   task automatic t_write();
      logic [3:0] tbl[4] = '{4'hF, 4'h3, 4'hC, 4'h9};
      for (int i = 0; i < 4; i++) begin
         op(1'b1, tbl[i], 2'h2, 10'h2AA);
         chk("bw", {4'h0, bw_acc}, {4'h0, tbl[i]});
         chk("parity_wr", par_n[7:0], 8'h00);
      end
   endtask

   // Page mode: same row across banks keeps the row strobe
   task automatic t_page();
      @(posedge i_clock);
      i_page_mode <= 1'b1;
      op(1'b0, 4'hF, 2'h0, 10'h005);
      op(1'b0, 4'hF, 2'h3, 10'h005);
      chk("page_ras", ras_fall[7:0], 8'h00);
      chk("page_cas", {4'h0, cas_acc}, 8'h08);
      @(posedge i_clock);
      i_page_mode <= 1'b0;
   endtask

   // Refresh with a prompt and a slow channel slave
   task automatic t_refresh();
      for (int i = 0; i < 2; i++) begin
         @(posedge i_clock);
         clr();
         dly <= i ? 4'h9 : 4'h1;
         i_refresh <= 1'b1;
         wait_ready(80);
         chk("ref_cas", {4'h0, cas_acc}, 8'h00);
         chk("ref_ras", {7'h00, ras_fall > 0}, 8'h01);
         chk("ref_chan", start_n[7:0], 8'h01);
         chk("ref_order", {7'h00, ready_at > done_at && done_at > 0}, 8'h01);
         @(posedge i_clock);
         i_refresh <= 1'b0;
         repeat (30) @(posedge i_clock);
      end
   endtask

   // Split address bits follow their inputs independently
   task automatic t_split();
      i_addr_18 <= 1'b1;
      i_addr_19 <= 1'b0;
      repeat (3) @(posedge i_clock);
      chk("split01", {6'h00, o_split_addr_bit_hi, o_split_addr_bit_lo}, 8'h01);
      i_addr_18 <= 1'b0;
      i_addr_19 <= 1'b1;
      repeat (3) @(posedge i_clock);
      chk("split10", {6'h00, o_split_addr_bit_hi, o_split_addr_bit_lo}, 8'h02);
   endtask

   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      i_rst = 1'b1; i_cycle_start = 1'b0; i_write = 1'b0; i_page_mode = 1'b0;
      i_refresh = 1'b0; i_addr_18 = 1'b0; i_addr_19 = 1'b0; i_byte_enable = 4'h0;
      i_bank = 2'h0; i_row = 10'h000; dly = 4'h2; w_exp = 1'b0; ras_q = 1'b0;
      clr();
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      @(negedge i_clock);
      chk("idle", {o_cas, o_dram_lane_enable}, 8'h00);
      t_read_banks();
      t_write();
      t_page();
      t_refresh();
      t_split();
      chk("bad_cas", bad_cas[7:0], 8'h00);
      wrap_up();
   end
endmodule // test_dbs_strobe_control
